/* core/vrt_tracker.sv */
// Functional notes
// [R01] preparation busy after a start of recording lasts at most one second
// [R02] start-recording function shows the whole preparation time as busy
// [R03] without start function, first write into the first unit shows preparation busy
// [R04] host drives link clock at 35 MHz or more in x15 range
// [R05] host may use any link clock from 26 to 52 MHz in x30 range
// [R06] host never uses grade 3 in the x15 range
// [R07] host issues one to eight directory updates before a session
// [R08] set-free assigns one to eight units and restarts sequential tracking
// [R09] host writes sequentially in recording-unit steps from the lowest unit
// [R10] non-sequential write in assigned units silently ends recording mode
// [R11] host repeats start after a boundary when the previous unit was incomplete
// [R12] host may continue with another set-free after all units are written
// [R13] set-free before the active unit is full flags undefined unwritten data
// [R14] a unit written completely in order is released; recording continues (code clears recording once the last assigned unit is released)
// [R15] suspend releases all units and ends the session
// [R16] a violating command with assigned units releases all and ends the session
// [R17] listed plain commands terminate the session
// [R18] non-sequential single write terminates; other single writes break span timing
// [R19] multi-block writes: non-sequential terminates; odd length or start breaks span
// [R20] commands 34 to 37: non-sequential terminates; odd length breaks span
// [R21] erase whose range overlaps an assigned unit terminates the session
// [R22] listed application commands terminate the session
// [R23] next expected address and assigned-unit count update on set-free and on every sequential write
module vrt_tracker #(
    parameter int unsigned AU_BLOCKS    = vrt_pkg::AU_BLOCKS_DEF,
    parameter int unsigned PREP_MAX_CYC = vrt_pkg::PREP_MAX_CYC
) (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               linkClk,
    input  wire logic               linkRst_n,
    input  wire vrt_pkg::vrt_cmd_s  linkCmd,
    input  wire logic               linkCmdValid,
    output logic                    linkCmdReady,
    output logic                    linkBusy,
    input  wire logic               prepDone,
    output vrt_pkg::vrt_stat_s      status,
    output logic                    sessionEnd
);
    localparam int unsigned AU_SHIFT = $clog2(AU_BLOCKS);

    if ((AU_BLOCKS != (1 << AU_SHIFT)) || (AU_BLOCKS < vrt_pkg::RU_BLOCKS)) begin : g_bad_au
        $error("unit size must be a power of two not below one recording unit");
    end
    if (PREP_MAX_CYC < 2) begin : g_bad_prep
        $error("preparation cap too small");
    end

    // link domain: capture and hand over one command at a time
    vrt_pkg::vrt_cmd_s heldCmd_reg;
    logic              reqTgl_reg;
    logic              ackSeen_reg;
    logic              ackSync;
    logic              busySync;
    logic              linkAccept;

    assign linkAccept = linkCmdValid && linkCmdReady;

    always_ff @(posedge linkClk) begin
        if (!linkRst_n) begin
            heldCmd_reg  <= '0;
            reqTgl_reg   <= 1'b0;
            linkCmdReady <= 1'b1;
        end else if (linkAccept) begin
            heldCmd_reg  <= linkCmd;
            reqTgl_reg   <= ~reqTgl_reg;
            linkCmdReady <= 1'b0;
        end else if (ackSync != ackSeen_reg) begin
            linkCmdReady <= 1'b1;
        end
    end

    always_ff @(posedge linkClk) begin
        if (!linkRst_n) begin
            ackSeen_reg <= 1'b0;
            linkBusy    <= 1'b0;
        end else begin
            ackSeen_reg <= ackSync;
            linkBusy    <= busySync;
        end
    end

    // main domain
    logic reqSync;
    logic reqSeen_reg;
    logic ackTgl_reg;
    logic take;

    vrt_sync #(.W(1)) u_req (
        .clk       (mclk),
        .rstSync_n (rst_n),
        .d         (reqTgl_reg),
        .q         (reqSync)
    );

    vrt_sync #(.W(2)) u_back (
        .clk       (linkClk),
        .rstSync_n (linkRst_n),
        .d         ({ackTgl_reg, status.prepBusy}),
        .q         ({ackSync, busySync})
    );

    assign take = reqSync != reqSeen_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reqSeen_reg <= 1'b0;
            ackTgl_reg  <= 1'b0;
        end else begin
            reqSeen_reg <= reqSync;
            ackTgl_reg  <= ackTgl_reg ^ take;
        end
    end

    function automatic logic isTerminator(input vrt_pkg::vrt_cmd_s c);
        if (c.isApp) begin
            return c.index inside {[6'h01:6'h0C], 6'h11, [6'h13:6'h15], 6'h18, 6'h1B, // [R22]
                                   [6'h1D:6'h25], [6'h27:6'h2A], 6'h32, [6'h34:6'h36],
                                   [6'h38:6'h3F]};
        end
        return c.index inside {[6'h00:6'h0B], [6'h0E:6'h10], 6'h16, [6'h1A:6'h1F], // [R17]
                               [6'h29:6'h2F], 6'h33, 6'h38, [6'h3C:6'h3F]};
    endfunction

    vrt_pkg::vrt_cmd_s c;
    logic [31:0]       auBase_reg;
    logic [3:0]        auLeft_reg;
    logic [31:0]       nextLba_reg;
    logic [31:0]       eraseLo_reg;
    logic [31:0]       eraseHi_reg;
    logic              recording_reg;
    logic              spanBroken_reg;
    logic              undef_reg;
    logic              prepared_reg;
    logic              prepBusy_reg;
    logic [31:0]       prepCnt_reg;

    logic        isCtrl;
    logic        isWrite;
    logic        inAssigned;
    logic        seqOk;
    logic        spanBad;
    logic        eraseHit;
    logic        termCmd;
    logic        seqWrite;
    logic        firstWr;
    logic        startPrep;
    logic [15:0] blocks;
    logic [31:0] auEnd;
    logic [31:0] newNext;
    logic [31:0] doneAus;
    logic [3:0]  relAus;
    logic [3:0]  newLeft;

    always_comb begin
        c          = heldCmd_reg;
        isCtrl     = !c.isApp && (c.index == vrt_pkg::CMD_CTRL);
        isWrite    = !c.isApp && (c.index inside {vrt_pkg::CMD_WR1, vrt_pkg::CMD_WRN,
                     vrt_pkg::CMD_WR50, vrt_pkg::CMD_WR57,
                     [vrt_pkg::CMD_X_LO:vrt_pkg::CMD_X_HI]});
        blocks     = (c.index == vrt_pkg::CMD_WR1) ? 16'h0001 : c.blkCnt;
        auEnd      = auBase_reg + (32'(auLeft_reg) << AU_SHIFT);
        inAssigned = (auLeft_reg != 4'h0) && (c.addr >= auBase_reg) && (c.addr < auEnd);
        seqOk      = c.addr == nextLba_reg;
        spanBad    = (c.index == vrt_pkg::CMD_WR1) // [R18]
                   || (blocks[vrt_pkg::RU_SHIFT-1:0] != '0) // [R19] [R20]
                   || ((c.index inside {vrt_pkg::CMD_WRN, vrt_pkg::CMD_WR50, vrt_pkg::CMD_WR57})
                       && (c.addr[vrt_pkg::RU_SHIFT-1:0] != '0)); // [R19]
        eraseHit   = !c.isApp && (c.index == vrt_pkg::CMD_ERASE)
                   && (eraseLo_reg < auEnd) && (eraseHi_reg >= auBase_reg); // [R21]
        termCmd    = take && (auLeft_reg != 4'h0) && (isTerminator(c) || eraseHit
                   || (isWrite && inAssigned && !seqOk)); // [R10] [R16] [R18] [R19] [R20]
        seqWrite   = take && isWrite && inAssigned && seqOk && !termCmd;
        newNext    = nextLba_reg + 32'(blocks); // [R23]
        doneAus    = (newNext - auBase_reg) >> AU_SHIFT;
        relAus     = (doneAus >= 32'(auLeft_reg)) ? auLeft_reg : doneAus[3:0];
        newLeft    = auLeft_reg - relAus; // [R14]
        firstWr    = seqWrite && !prepared_reg && !recording_reg; // [R03]
        startPrep  = (take && isCtrl && (c.func == vrt_pkg::FN_START)) || firstWr; // [R02]
    end

    // erase range set by the start and end commands
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            eraseLo_reg <= 32'h0000_0000;
            eraseHi_reg <= 32'h0000_0000;
        end else if (take && !c.isApp && (c.index == vrt_pkg::CMD_ERS_LO)) begin
            eraseLo_reg <= c.addr;
        end else if (take && !c.isApp && (c.index == vrt_pkg::CMD_ERS_HI)) begin
            eraseHi_reg <= c.addr;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            auBase_reg     <= 32'h0000_0000;
            auLeft_reg     <= 4'h0;
            nextLba_reg    <= 32'h0000_0000;
            recording_reg  <= 1'b0;
            spanBroken_reg <= 1'b0;
            undef_reg      <= 1'b0;
            prepared_reg   <= 1'b0;
            sessionEnd     <= 1'b0;
        end else begin
            sessionEnd <= 1'b0;
            if (termCmd) begin
                auLeft_reg    <= 4'h0; // [R16]
                recording_reg <= 1'b0;
                sessionEnd    <= 1'b1;
            end else if (take && isCtrl && (c.func == vrt_pkg::FN_SET_FREE)
                         && (c.auCnt >= 4'h1) && (c.auCnt <= 4'(vrt_pkg::MAX_AU))) begin
                auBase_reg     <= c.addr & ~(32'(AU_BLOCKS) - 32'h1); // [R08]
                nextLba_reg    <= c.addr & ~(32'(AU_BLOCKS) - 32'h1); // [R23]
                auLeft_reg     <= c.auCnt; // [R23]
                spanBroken_reg <= 1'b0;
                prepared_reg   <= 1'b0;
                if ((auLeft_reg != 4'h0) && (nextLba_reg != auBase_reg)) begin
                    undef_reg <= 1'b1; // [R13]
                end
            end else if (take && isCtrl && (c.func == vrt_pkg::FN_SUSPEND)) begin
                auLeft_reg    <= 4'h0; // [R15]
                recording_reg <= 1'b0;
                sessionEnd    <= auLeft_reg != 4'h0;
            end else if (take && isCtrl && (c.func == vrt_pkg::FN_START)) begin
                recording_reg  <= auLeft_reg != 4'h0;
                spanBroken_reg <= 1'b0;
                prepared_reg   <= 1'b1;
            end else if (take && isCtrl && (c.func == vrt_pkg::FN_UPDATE)) begin
                recording_reg <= 1'b0;
            end else if (seqWrite) begin
                nextLba_reg    <= newNext; // [R23]
                auBase_reg     <= auBase_reg + (32'(relAus) << AU_SHIFT); // [R14]
                auLeft_reg     <= newLeft; // [R14]
                spanBroken_reg <= spanBroken_reg | spanBad; // [R18] [R19] [R20]
                prepared_reg   <= 1'b1;
                if (newLeft == 4'h0) begin
                    recording_reg <= 1'b0;
                end
            end
        end
    end

    // preparation busy, capped however slow the back end is
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prepBusy_reg <= 1'b0;
            prepCnt_reg  <= 32'h0000_0000;
        end else if (startPrep) begin
            prepBusy_reg <= 1'b1; // [R02] [R03]
            prepCnt_reg  <= 32'h0000_0000;
        end else if (prepBusy_reg) begin
            prepCnt_reg <= prepCnt_reg + 32'h1;
            if (prepDone || (prepCnt_reg >= PREP_MAX_CYC - 2)) begin
                prepBusy_reg <= 1'b0; // [R01]
            end
        end
    end

    assign status = '{recording:     recording_reg,
                      spanBroken:    spanBroken_reg,
                      dataUndefined: undef_reg,
                      prepBusy:      prepBusy_reg,
                      auLeft:        auLeft_reg,
                      auBase:        auBase_reg,
                      nextLba:       nextLba_reg};

    sequence sStart;
        take && isCtrl && (c.func == vrt_pkg::FN_START);
    endsequence

    sequence sBadWrite;
        take && isWrite && inAssigned && !seqOk;
    endsequence

    AST_PREP_CAP: assert property (@(posedge mclk) disable iff (!rst_n) // [R01]
        prepBusy_reg |-> prepCnt_reg < PREP_MAX_CYC - 1)
        else $error("preparation busy exceeded cap");

    AST_START_BUSY: assert property (@(posedge mclk) disable iff (!rst_n) // [R02]
        sStart |=> prepBusy_reg && prepCnt_reg == 32'h0)
        else $error("start function did not raise busy");

    AST_FIRST_WR_BUSY: assert property (@(posedge mclk) disable iff (!rst_n) // [R03]
        firstWr |=> prepBusy_reg ##1 (prepBusy_reg || $past(prepDone)))
        else $error("first write without preparation busy");

    AST_NONSEQ_END: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
        sBadWrite |=> !recording_reg && auLeft_reg == 4'h0 && sessionEnd)
        else $error("non-sequential write kept session");

    AST_TERM_CMD: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
        (take && isTerminator(c) && auLeft_reg != 4'h0) |=> auLeft_reg == 4'h0 ##1 !sessionEnd)
        else $error("terminating command ignored");

    AST_SET_FREE: assert property (@(posedge mclk) disable iff (!rst_n) // [R08]
        (take && isCtrl && c.func == vrt_pkg::FN_SET_FREE
         && c.auCnt >= 4'h1 && c.auCnt <= 4'(vrt_pkg::MAX_AU))
        |=> auLeft_reg == $past(c.auCnt) && nextLba_reg == auBase_reg && !spanBroken_reg)
        else $error("set-free did not assign units");

    AST_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
        (seqWrite && relAus != 4'h0) |=> auLeft_reg == $past(auLeft_reg) - $past(relAus))
        else $error("full unit not released");

    AST_SUSPEND: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
        (take && isCtrl && c.func == vrt_pkg::FN_SUSPEND && !termCmd)
        |=> auLeft_reg == 4'h0 && !recording_reg)
        else $error("suspend kept units");

    AST_UNDEF: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
        $rose(undef_reg) |-> $past(auLeft_reg) != 4'h0 && $past(take))
        else $error("undefined flag without early set-free");

    AST_SPAN: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
        (seqWrite && spanBad) |=> spanBroken_reg)
        else $error("span break not flagged");

    AST_ADVANCE: assert property (@(posedge mclk) disable iff (!rst_n) // [R23]
        seqWrite |=> nextLba_reg == $past(nextLba_reg) + 32'($past(blocks)))
        else $error("next address not advanced");

    AST_VIOLATION: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
        termCmd |=> auLeft_reg == 4'h0 && !recording_reg && sessionEnd)
        else $error("violation kept session");

    AST_ERASE_END: assert property (@(posedge mclk) disable iff (!rst_n) // [R21]
        (take && eraseHit && auLeft_reg != 4'h0) |=> auLeft_reg == 4'h0 && sessionEnd)
        else $error("overlapping erase kept session");

    AST_APP_TERM: assert property (@(posedge mclk) disable iff (!rst_n) // [R22]
        (take && c.isApp && isTerminator(c) && auLeft_reg != 4'h0) |=> sessionEnd)
        else $error("application command kept session");

    AST_SET_FREE_RANGE: assert property (@(posedge mclk) disable iff (!rst_n) // [R08]
        (take && isCtrl && c.func == vrt_pkg::FN_SET_FREE
         && (c.auCnt == 4'h0 || c.auCnt > 4'(vrt_pkg::MAX_AU)))
        |=> auLeft_reg == $past(auLeft_reg))
        else $error("set-free outside one to eight accepted");

    AST_END_PULSE: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
        sessionEnd |=> !sessionEnd)
        else $error("session end longer than one cycle");

    AST_REC_STOP: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
        (seqWrite && newLeft == 4'h0) |=> !recording_reg && auLeft_reg == 4'h0)
        else $error("recording kept after last unit");

    AST_HS_HOLD: assert property (@(posedge linkClk) disable iff (!linkRst_n)
        linkAccept |=> !linkCmdReady[*2])
        else $error("ready returned too early");
endmodule

/* core/vrt_pkg.sv */
package vrt_pkg;
    // block counts are in 512-byte blocks
    localparam int unsigned RU_BLOCKS     = 32'h0000_0400;
    localparam int unsigned RU_SHIFT      = 10;
    localparam int unsigned AU_BLOCKS_DEF = 32'h0000_2000;
    localparam int unsigned MAX_AU        = 8;
    localparam int unsigned PREP_MAX_MS   = 1000;
    localparam longint      MCLK_HZ       = 64'h0000_0000_0131_2D00;
    localparam int unsigned PREP_MAX_CYC  = 32'((64'(PREP_MAX_MS) * MCLK_HZ) / 64'h3E8);

    localparam logic [5:0] CMD_CTRL   = 6'h14;
    localparam logic [5:0] CMD_WR1    = 6'h18;
    localparam logic [5:0] CMD_WRN    = 6'h19;
    localparam logic [5:0] CMD_WR50   = 6'h32;
    localparam logic [5:0] CMD_WR57   = 6'h39;
    localparam logic [5:0] CMD_ERS_LO = 6'h20;
    localparam logic [5:0] CMD_ERS_HI = 6'h21;
    localparam logic [5:0] CMD_ERASE  = 6'h26;
    localparam logic [5:0] CMD_X_LO   = 6'h22;
    localparam logic [5:0] CMD_X_HI   = 6'h25;

    // recording-control function codes, values arbitrary
    localparam logic [3:0] FN_START    = 4'h0;
    localparam logic [3:0] FN_UPDATE   = 4'h1;
    localparam logic [3:0] FN_SUSPEND  = 4'h5;
    localparam logic [3:0] FN_SET_FREE = 4'h7;

    typedef struct packed {
        logic        isApp;
        logic [5:0]  index;
        logic [3:0]  func;
        logic [3:0]  auCnt;
        logic [31:0] addr;
        logic [15:0] blkCnt;
    } vrt_cmd_s;

    typedef struct packed {
        logic        recording;
        logic        spanBroken;
        logic        dataUndefined;
        logic        prepBusy;
        logic [3:0]  auLeft;
        logic [31:0] auBase;
        logic [31:0] nextLba;
    } vrt_stat_s;
endpackage

/* core/vrt_sync.sv */
module vrt_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstSync_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    if (W < 1) begin : g_bad
        $error("vrt_sync width must be at least one");
    end

    always_ff @(posedge clk) begin
        if (!rstSync_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* test/vrt_host_model.sv */
module vrt_host_model (
    input  wire logic         linkClk,
    output vrt_pkg::vrt_cmd_s linkCmd,
    output logic              linkCmdValid,
    input  wire logic         linkCmdReady,
    input  wire logic         linkBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busySeen;
    initial begin
        linkCmd      = '0;
        linkCmdValid = 1'b0;
        busySeen     = 1'b0;
    end
    // one command per handshake, then waits out busy
    task automatic send(input vrt_pkg::vrt_cmd_s c, output logic ok);
        int n;
        int m;
        busySeen = 1'b0;
        @(posedge linkClk);
        #1;
        linkCmd      = c;
        linkCmdValid = 1'b1;
        for (n = 0; n < 400 && linkCmdReady !== 1'b1; n++) begin
            @(posedge linkClk);
            #1;
        end
        @(posedge linkClk);
        #1;
        linkCmdValid = 1'b0;
        // released bus shows the inverse, not the last command
        linkCmd      = ~c;
        for (m = 0; m < 400 && !(linkCmdReady === 1'b1 && linkBusy === 1'b0); m++) begin
            @(posedge linkClk);
            #1;
            if (linkBusy === 1'b1) begin
                busySeen = 1'b1;
            end
        end
        ok = (n < 400 && m < 400);
    endtask
endmodule

/* test/test_video_recording_tracker.sv */
module test_video_recording_tracker;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned AU   = 1024;
    localparam int unsigned PMAX = 40;
    logic               mclk      = 1'b0;
    logic               linkClk   = 1'b0;
    logic               rst_n     = 1'b0;
    logic               linkRst_n = 1'b0;
    logic               prepDone  = 1'b0;
    logic               linkCmdValid, linkCmdReady, linkBusy, sessionEnd, ok;
    vrt_pkg::vrt_cmd_s  linkCmd;
    vrt_pkg::vrt_stat_s status;
    int                 errorCnt = 0, checkCount = 0, endCnt = 0, busyRun = 0, busyMax = 0;

    vrt_tracker #(.AU_BLOCKS(AU), .PREP_MAX_CYC(PMAX)) u_vrt_tracker (
        .mclk(mclk), .rst_n(rst_n), .linkClk(linkClk), .linkRst_n(linkRst_n),
        .linkCmd(linkCmd), .linkCmdValid(linkCmdValid), .linkCmdReady(linkCmdReady),
        .linkBusy(linkBusy), .prepDone(prepDone), .status(status), .sessionEnd(sessionEnd));
    vrt_host_model u_vrt_host_model (
        .linkClk(linkClk), .linkCmd(linkCmd), .linkCmdValid(linkCmdValid),
        .linkCmdReady(linkCmdReady), .linkBusy(linkBusy));

    always #25 mclk = ~mclk;
    // free link clock, its edges meet an mclk edge every 75 ns
    always #3 linkClk = ~linkClk;
    // counts end pulses and the longest busy run
    always @(posedge mclk) begin
        if (sessionEnd === 1'b1) endCnt <= endCnt + 1;
        busyRun <= (status.prepBusy === 1'b1) ? busyRun + 1 : 0;
        if (busyRun > busyMax) busyMax <= busyRun;
    end

    task automatic finishTest();
        if (errorCnt == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic app, input logic [5:0] idx, input logic [3:0] fn,
                       input logic [3:0] au, input logic [31:0] a, input logic [15:0] n);
        u_vrt_host_model.send(vrt_pkg::vrt_cmd_s'{app, idx, fn, au, a, n}, ok);
        if (ok !== 1'b1) begin
            errorCnt++;
            $display("[ERR] handshake expected 1 seen 0");
            finishTest();
        end
        // end pulse reaches the counter one mclk edge after it rises
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic ctrl(input logic [3:0] fn, input logic [3:0] au, input logic [31:0] a);
        cmd(1'b0, vrt_pkg::CMD_CTRL, fn, au, a, 16'h0000);
    endtask
    function automatic int isTerm(input logic app, input int i);
        if (app) return int'((i >= 1 && i <= 12) || i == 17 || (i >= 19 && i <= 21) || i == 24
            || i == 27 || (i >= 29 && i <= 37) || (i >= 39 && i <= 42) || i == 50
            || (i >= 52 && i <= 54) || i >= 56);
        return int'(i <= 11 || (i >= 14 && i <= 16) || i == 22 || (i >= 26 && i <= 31)
            || (i >= 41 && i <= 47) || i == 51 || i == 56 || i >= 60);
    endfunction

    task automatic testRecord();
        int e;
        ctrl(vrt_pkg::FN_UPDATE, 4'h0, 32'h0);
        ctrl(vrt_pkg::FN_SET_FREE, 4'h2, 32'h0000_1005);
        chk("auBase", 32'h0000_1000, status.auBase);
        chk("auLeft", 32'h2, status.auLeft);
        busyMax = 0;
        ctrl(vrt_pkg::FN_START, 4'h0, 32'h0);
        chk("start busy", 32'h1, u_vrt_host_model.busySeen);
        chk("recording", 32'h1, status.recording);
        repeat (3) @(posedge mclk);
        chk("prep bound", 32'h1, busyMax <= PMAX && busyMax > 0);
        cmd(1'b0, vrt_pkg::CMD_WRN, 4'h0, 4'h0, 32'h0000_1000, 16'h0400);
        chk("nextLba", 32'h0000_1400, status.nextLba);
        chk("auLeft", 32'h1, status.auLeft);
        chk("auBase", 32'h0000_1400, status.auBase);
        chk("spanBroken", 32'h0, status.spanBroken);
        cmd(1'b0, vrt_pkg::CMD_WR1, 4'h0, 4'h0, 32'h0000_1400, 16'h0001);
        chk("spanBroken", 32'h1, status.spanBroken);
        chk("nextLba", 32'h0000_1401, status.nextLba);
        e = endCnt;
        cmd(1'b0, vrt_pkg::CMD_WRN, 4'h0, 4'h0, 32'h0000_1600, 16'h0400);
        chk("end count", e + 1, endCnt);
        chk("auLeft", 32'h0, status.auLeft);
        chk("recording", 32'h0, status.recording);
    endtask
    task automatic testTable();
        int e;
        for (int app = 0; app < 2; app++) begin
            for (int i = 0; i < 64; i++) begin
                if (app == 0 && i == 38) continue;
                ctrl(vrt_pkg::FN_SET_FREE, 4'h1, 32'h0000_8000);
                e = endCnt;
                cmd(app[0], i[5:0], 4'hF, 4'h0, 32'hF000_0000, 16'h0001);
                chk($sformatf("end count %0d %0d", app, i), e + isTerm(app[0], i), endCnt);
            end
        end
    endtask
    task automatic testErase();
        int e;
        ctrl(vrt_pkg::FN_SET_FREE, 4'h1, 32'h0000_2000);
        cmd(1'b0, vrt_pkg::CMD_ERS_LO, 4'h0, 4'h0, 32'h0000_1F00, 16'h0000);
        cmd(1'b0, vrt_pkg::CMD_ERS_HI, 4'h0, 4'h0, 32'h0000_2010, 16'h0000);
        e = endCnt;
        cmd(1'b0, vrt_pkg::CMD_ERASE, 4'h0, 4'h0, 32'h0, 16'h0000);
        chk("erase end", e + 1, endCnt);
        ctrl(vrt_pkg::FN_SET_FREE, 4'h2, 32'h0000_2000);
        ctrl(vrt_pkg::FN_START, 4'h0, 32'h0);
        ctrl(vrt_pkg::FN_UPDATE, 4'h0, 32'h0);
        chk("recording", 32'h0, status.recording);
        e = endCnt;
        ctrl(vrt_pkg::FN_SUSPEND, 4'h0, 32'h0);
        chk("suspend end", e + 1, endCnt);
        chk("auLeft", 32'h0, status.auLeft);
    endtask
    task automatic testNoStart();
        @(posedge mclk);
        #1 prepDone = 1'b1;
        ctrl(vrt_pkg::FN_SET_FREE, 4'h3, 32'h0000_5000);
        ctrl(vrt_pkg::FN_START, 4'h0, 32'h0);
        cmd(1'b0, vrt_pkg::CMD_WR50, 4'h0, 4'h0, 32'h0000_5000, 16'h0400);
        cmd(1'b0, vrt_pkg::CMD_X_LO, 4'h0, 4'h0, 32'h0000_5400, 16'h0400);
        cmd(1'b0, vrt_pkg::CMD_WR57, 4'h0, 4'h0, 32'h0000_5800, 16'h0400);
        chk("auLeft", 32'h0, status.auLeft);
        chk("recording", 32'h0, status.recording);
        chk("spanBroken", 32'h0, status.spanBroken);
        chk("nextLba", 32'h0000_5C00, status.nextLba);
        ctrl(vrt_pkg::FN_SET_FREE, 4'h9, 32'h0000_7000);
        chk("auLeft", 32'h0, status.auLeft);
        ctrl(vrt_pkg::FN_SET_FREE, 4'h1, 32'h0000_3000);
        chk("dataUndefined", 32'h0, status.dataUndefined);
        cmd(1'b0, vrt_pkg::CMD_WRN, 4'h0, 4'h0, 32'h0000_3000, 16'h0200);
        chk("first write busy", 32'h1, u_vrt_host_model.busySeen);
        chk("spanBroken", 32'h1, status.spanBroken);
        chk("nextLba", 32'h0000_3200, status.nextLba);
        ctrl(vrt_pkg::FN_SET_FREE, 4'h1, 32'h0000_4000);
        chk("dataUndefined", 32'h1, status.dataUndefined);
        @(posedge mclk);
        #1 prepDone = 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        #1 rst_n = 1'b1;
        @(posedge linkClk);
        #1 linkRst_n = 1'b1;
        repeat (2) @(posedge mclk);
        chk("idle status", 32'h0, {status.recording, status.spanBroken, status.auLeft});
        chk("ready", 32'h1, linkCmdReady);
        testRecord();
        testTable();
        testErase();
        testNoStart();
        finishTest();
    end
    initial begin
        #3000000;
        errorCnt++;
        $display("[ERR] run expected done seen hang");
        finishTest();
    end
endmodule
